// ==== fcc_defs.vh ====
// Register offsets, field positions, reset values and timing for loop control
`ifndef FCC_DEFS_VH
`define FCC_DEFS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FCC_ADDR_ENABLE 8'h74
`define FCC_ADDR_OUTDIV 8'h75
`define FCC_ADDR_FRAC 8'h76
`define FCC_ADDR_INTGAIN 8'h77
`define FCC_ADDR_REFSEL 8'h78
`define FCC_ADDR_SYSSEL 8'h80
`define FCC_ADDR_STATUS 8'h81
`define FCC_ADDR_FRCSEL 8'hF7
`define FCC_ADDR_FRCVAL 8'hF8
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCC_EN_LOOP 0
`define FCC_EN_OSC 1
`define FCC_EN_FRACN 2
`define FCC_OUTDIV_LSB 8
`define FCC_OUTDIV_MSB 13
`define FCC_RATE_LSB 4
`define FCC_RATE_MSB 6
`define FCC_RATIO_LSB 0
`define FCC_RATIO_MSB 2
`define FCC_INT_LSB 5
`define FCC_INT_MSB 14
`define FCC_GAIN_LSB 0
`define FCC_GAIN_MSB 3
`define FCC_PDIV_LSB 3
`define FCC_PDIV_MSB 4
`define FCC_SRC_LSB 0
`define FCC_SRC_MSB 1
`define FCC_FRC_BIT 0
`define FCC_FRCVAL_LSB 0
`define FCC_FRCVAL_MSB 5
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FCC_RST_RATIO 3'h7
`define FCC_RST_FRAC 16'h0000
`define FCC_RST_INT 10'h177
`define FCC_RST_GAIN 4'h0
`define FCC_RST_PDIV 2'h0
`define FCC_RST_SRC 2'h0
`define FCC_RST_OUTDIV 6'h00
`define FCC_RST_RATE 3'h0
`define FCC_RST_FRCVAL 6'h19
// ----------------------------------------------------------------------
// Source codes and timing
// ----------------------------------------------------------------------
`define FCC_SRC_MCLK 2'h0
`define FCC_SRC_BCLK 2'h1
`define FCC_SRC_FCLK 2'h2
`define FCC_OUTDIV_MIN 6'h03
`define FCC_LOCK_TOL 8'h02
`define FCC_LOCK_GOOD 4'h8
`endif

// ==== fcc_top.v ====
// Frequency-locked loop control: registers, reference path, digital loop
`timescale 1ns/1ns
`include "fcc_defs.vh"

// Operation
// - Ratio codes 0-3 divide by 1,2,4,8; top bit set gives 16; reset 111.
// - Sixteen-bit fractional multiplier, MSB weight one half, resets zero.
// - Ten-bit integer multiplier in bits 14:5, LSB weight one, reset 177h.
// - Four-bit gain scales loop error by 2^code up to 32768; reset times one.
// - Two-bit pre-divider in bits 4:3 divides reference by 1,2,4,8.
// - Source 00 master clock, 01 bit clock, 10 frame clock, 11 reserved.
// - Loop keeps running stably after its reference stops.
// - Forced select clear gives normal control; set drives oscillator.
// - Six-bit forced value accepts all codes; resets to 011001.
// - Internal lock indication drives the interrupt logic.
// - Lock indication available for a general purpose pin.
// - Loop clock available on a pin regardless of system clock choice.
// - Output divider divides by code for 3-62, all ones gives 64.
module fcc_top #(
	parameter CNT_W = 24
) (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [7:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	input wire i_mclk,
	input wire i_bclk,
	input wire i_fclk,
	input wire i_vco_clk,
	output reg [5:0] o_osc_ctrl,
	output reg [11:0] o_osc_level,
	output wire o_osc_enable,
	output reg [5:0] o_out_div,
	output reg [2:0] o_ctrl_rate,
	output wire o_loop_clk,
	output reg o_system_clock_sel,
	output reg o_lock,
	output reg o_lock_irq
);

// ----------------------------------------------------------------------
// Register state
// ----------------------------------------------------------------------
reg loop_enable;
reg oscillator_enable;
reg fractional_mode_enable;
reg [5:0] output_divider;
reg [2:0] control_block_rate;
reg [2:0] reference_ratio;
reg [15:0] fractional_multiplier;
reg [9:0] integer_multiplier;
reg [3:0] loop_gain;
reg [1:0] reference_predivider;
reg [1:0] reference_source;
reg forced_control_select;
reg [5:0] forced_oscillator_value;
reg system_clock_source_select;

// Register writes
always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		loop_enable <= 1'b0;
		oscillator_enable <= 1'b0;
		fractional_mode_enable <= 1'b0;
		output_divider <= `FCC_RST_OUTDIV;
		control_block_rate <= `FCC_RST_RATE;
		reference_ratio <= `FCC_RST_RATIO;
		fractional_multiplier <= `FCC_RST_FRAC;
		integer_multiplier <= `FCC_RST_INT;
		loop_gain <= `FCC_RST_GAIN;
		reference_predivider <= `FCC_RST_PDIV;
		reference_source <= `FCC_RST_SRC;
		forced_control_select <= 1'b0;
		forced_oscillator_value <= `FCC_RST_FRCVAL;
		system_clock_source_select <= 1'b0;
	end else if (i_wr) begin
		case (i_addr)
		`FCC_ADDR_ENABLE: begin
			loop_enable <= i_wdata[`FCC_EN_LOOP];
			oscillator_enable <= i_wdata[`FCC_EN_OSC];
			fractional_mode_enable <= i_wdata[`FCC_EN_FRACN];
		end
		`FCC_ADDR_OUTDIV: begin
			output_divider <= i_wdata[`FCC_OUTDIV_MSB:`FCC_OUTDIV_LSB];
			control_block_rate <= i_wdata[`FCC_RATE_MSB:`FCC_RATE_LSB];
			reference_ratio <= i_wdata[`FCC_RATIO_MSB:`FCC_RATIO_LSB];
		end
		`FCC_ADDR_FRAC: fractional_multiplier <= i_wdata;
		`FCC_ADDR_INTGAIN: begin
			integer_multiplier <= i_wdata[`FCC_INT_MSB:`FCC_INT_LSB];
			loop_gain <= i_wdata[`FCC_GAIN_MSB:`FCC_GAIN_LSB];
		end
		`FCC_ADDR_REFSEL: begin
			reference_predivider <= i_wdata[`FCC_PDIV_MSB:`FCC_PDIV_LSB];
			reference_source <= i_wdata[`FCC_SRC_MSB:`FCC_SRC_LSB];
		end
		`FCC_ADDR_SYSSEL: system_clock_source_select <= i_wdata[0];
		`FCC_ADDR_FRCSEL: forced_control_select <= i_wdata[`FCC_FRC_BIT];
		`FCC_ADDR_FRCVAL:
			forced_oscillator_value <= i_wdata[`FCC_FRCVAL_MSB:0];
		default: ;
		endcase
	end
end

// Read data, one cycle after the read strobe; unmapped reads zero
always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		o_rdata <= 16'h0000;
	end else if (i_rd) begin
		case (i_addr)
		`FCC_ADDR_ENABLE: o_rdata <= {13'h0000, fractional_mode_enable,
			oscillator_enable, loop_enable};
		`FCC_ADDR_OUTDIV: o_rdata <= {2'h0, output_divider, 1'b0,
			control_block_rate, 1'b0, reference_ratio};
		`FCC_ADDR_FRAC: o_rdata <= fractional_multiplier;
		`FCC_ADDR_INTGAIN: o_rdata <= {1'b0, integer_multiplier, 1'b0,
			loop_gain};
		`FCC_ADDR_REFSEL: o_rdata <= {11'h000, reference_predivider, 1'b0,
			reference_source};
		`FCC_ADDR_SYSSEL: o_rdata <= {15'h0000, system_clock_source_select};
		`FCC_ADDR_STATUS: o_rdata <= {15'h0000, o_lock};
		`FCC_ADDR_FRCSEL: o_rdata <= {15'h0000, forced_control_select};
		`FCC_ADDR_FRCVAL: o_rdata <= {10'h000, forced_oscillator_value};
		default: o_rdata <= 16'h0000;
		endcase
	end else begin
		o_rdata <= 16'h0000;
	end
end

// ----------------------------------------------------------------------
// Reference path: source select, pre-divide, ratio divide
// ----------------------------------------------------------------------
reg [2:0] ref_sync;
reg [3:0] pdiv_cnt;
reg [3:0] ratio_cnt;
reg ref_tick;
wire ref_raw;
wire ref_edge;
wire [3:0] pdiv_max;
wire [3:0] ratio_max;

// Code 11 is reserved and yields no reference at all
assign ref_raw = (reference_source == `FCC_SRC_MCLK) ? i_mclk :
	(reference_source == `FCC_SRC_BCLK) ? i_bclk :
	(reference_source == `FCC_SRC_FCLK) ? i_fclk : 1'b0;
assign ref_edge = ref_sync[1] & ~ref_sync[2];
assign pdiv_max = (4'h1 << reference_predivider) - 4'h1;
assign ratio_max = reference_ratio[2] ? 4'hF :
	((4'h1 << reference_ratio[1:0]) - 4'h1);

// Synchronise and divide the reference into a tick per divided period
always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		ref_sync <= 3'h0;
		pdiv_cnt <= 4'h0;
		ratio_cnt <= 4'h0;
		ref_tick <= 1'b0;
	end else begin
		ref_sync <= {ref_sync[1:0], ref_raw};
		ref_tick <= 1'b0;
		if (ref_edge) begin
			if (pdiv_cnt >= pdiv_max) begin
				pdiv_cnt <= 4'h0;
				if (ratio_cnt >= ratio_max) begin
					ratio_cnt <= 4'h0;
					ref_tick <= 1'b1;
				end else begin
					ratio_cnt <= ratio_cnt + 4'h1;
				end
			end else begin
				pdiv_cnt <= pdiv_cnt + 4'h1;
			end
		end
	end
end

// ----------------------------------------------------------------------
// Frequency detector: count oscillator edges per reference period
// ----------------------------------------------------------------------
reg [2:0] vco_sync;
reg [CNT_W-1:0] vco_cnt;
reg [CNT_W-1:0] meas;
reg meas_vld;
wire vco_edge;
wire [2:0] ratio_log;
wire [CNT_W+15:0] target;

assign vco_edge = vco_sync[1] & ~vco_sync[2];
assign ratio_log = reference_ratio[2] ? 3'h4 :
	{1'b0, reference_ratio[1:0]};
// A tick spans ratio pre-divided reference periods, so the count is N.K times ratio
// squared; kept with sixteen fraction bits
assign target = {{(CNT_W-10){1'b0}}, integer_multiplier,
	fractional_mode_enable ? fractional_multiplier : 16'h0000}
	<< {ratio_log, 1'b0};

always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		vco_sync <= 3'h0;
		vco_cnt <= {CNT_W{1'b0}};
		meas <= {CNT_W{1'b0}};
		meas_vld <= 1'b0;
	end else begin
		vco_sync <= {vco_sync[1:0], i_vco_clk};
		meas_vld <= ref_tick;
		if (ref_tick) begin
			meas <= vco_cnt;
			vco_cnt <= {CNT_W{1'b0}};
		end else if (vco_edge) begin
			vco_cnt <= vco_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
end

// ----------------------------------------------------------------------
// Loop filter: integrate gain-scaled error into oscillator level
// ----------------------------------------------------------------------
reg [3:0] good_cnt;
reg [3:0] miss_cnt;
wire signed [CNT_W+16:0] err;
wire signed [CNT_W+16:0] step;
wire [CNT_W+15:0] meas_q;
wire loop_run;
wire near;

assign meas_q = {meas, 16'h0000};
assign err = $signed({1'b0, target}) - $signed({1'b0, meas_q});
assign step = (err >>> 16) <<< loop_gain;
assign loop_run = loop_enable & oscillator_enable;
assign near = ((err >>> 16) < $signed({{(CNT_W+9){1'b0}}, `FCC_LOCK_TOL}))
	&& ((err >>> 16) > -$signed({{(CNT_W+9){1'b0}}, `FCC_LOCK_TOL}));

always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		o_osc_level <= 12'h800;
		good_cnt <= 4'h0;
		miss_cnt <= 4'h0;
		o_lock <= 1'b0;
	end else if (!loop_run || forced_control_select) begin
		good_cnt <= 4'h0;
		miss_cnt <= 4'h0;
		o_lock <= 1'b0;
	end else if (meas_vld) begin
		miss_cnt <= 4'h0;
		// Saturating integrator of the scaled error
		if (step > $signed({29'h0, 12'hFFF} - {29'h0, o_osc_level}))
			o_osc_level <= 12'hFFF;
		else if (step < -$signed({29'h0, o_osc_level}))
			o_osc_level <= 12'h000;
		else
			o_osc_level <= o_osc_level + step[11:0];
		if (near && good_cnt != `FCC_LOCK_GOOD)
			good_cnt <= good_cnt + 4'h1;
		else if (!near)
			good_cnt <= 4'h0;
		o_lock <= near && good_cnt == `FCC_LOCK_GOOD;
	end
	// With no reference ticks the level simply holds: stable output
end

// ----------------------------------------------------------------------
// Oscillator drive and clock outputs
// ----------------------------------------------------------------------
reg lock_q;

// Forced value takes over the oscillator control word when selected
always @(posedge i_ref_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		o_osc_ctrl <= `FCC_RST_FRCVAL;
		o_out_div <= 6'h00;
		o_ctrl_rate <= `FCC_RST_RATE;
		o_system_clock_sel <= 1'b0;
		lock_q <= 1'b0;
		o_lock_irq <= 1'b0;
	end else begin
		o_osc_ctrl <= forced_control_select ? forced_oscillator_value :
			o_osc_level[11:6];
		// Divide ratio equals code for 3..62, all ones gives 64; 0..2 reserved
		o_out_div <= (output_divider < `FCC_OUTDIV_MIN) ?
			`FCC_OUTDIV_MIN : output_divider;
		o_ctrl_rate <= control_block_rate;
		o_system_clock_sel <= system_clock_source_select;
		lock_q <= o_lock;
		o_lock_irq <= o_lock & ~lock_q;
	end
end

assign o_osc_enable = oscillator_enable;
// Loop clock reaches the pin mux whatever the system clock choice
assign o_loop_clk = i_vco_clk & loop_enable;

endmodule

// ==== fcc_ref_src.sv ====
// Far-side model: reference clock pins and oscillator clock
`timescale 1ns/1ns
module fcc_ref_src #(
	parameter REF_HALF = 400,
	parameter VCO_HALF = 100
) (
	input wire logic [2:0] i_run,
	output logic o_mclk,
	output logic o_bclk,
	output logic o_fclk,
	output logic o_vco_clk
);
	// Oscillator runs freely
	initial begin
		o_vco_clk = 1'b0;
		forever #VCO_HALF o_vco_clk = ~o_vco_clk;
	end
	// A pin toggles while its run bit is set and rests low otherwise
	initial begin
		{o_fclk, o_bclk, o_mclk} = 3'b000;
		forever #REF_HALF {o_fclk, o_bclk, o_mclk} =
			i_run & ~{o_fclk, o_bclk, o_mclk};
	end
endmodule

// ==== fcc_top_chk.sv ====
// Checker for the loop control block ports
`timescale 1ns/1ns
module fcc_top_chk (
	input wire i_ref_clk,
	input wire i_nrst,
	input wire [7:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [15:0] o_rdata,
	input wire i_vco_clk,
	input wire [5:0] o_osc_ctrl,
	input wire o_osc_enable,
	input wire [5:0] o_out_div,
	input wire o_loop_clk,
	input wire o_lock,
	input wire o_lock_irq
);
	reg en_loop;
	reg frc_sel;
	reg [5:0] frc_val;
	reg [5:0] od_sh;
	reg [15:0] frac_sh;
	wire [5:0] od_exp = (od_sh < 6'h03) ? 6'h03 : od_sh;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// ----
	// Shadow copies of written fields
	// ----
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			en_loop <= 1'b0;
			frc_sel <= 1'b0;
			frc_val <= 6'h19;
			od_sh <= 6'h00;
			frac_sh <= 16'h0000;
		end else if (i_wr) begin
			case (i_addr)
			8'h74: en_loop <= i_wdata[0];
			8'h75: od_sh <= i_wdata[13:8];
			8'h76: frac_sh <= i_wdata;
			8'hF7: frc_sel <= i_wdata[0];
			8'hF8: frc_val <= i_wdata[5:0];
			default: ;
			endcase
		end
	end
	// ----
	// Assertions
	// ----
	a_loop_clk_gate: assert property (o_loop_clk == (i_vco_clk && en_loop))
		else $error("loop clock gate wrong");
	a_outdiv_follow: assert property ($past(i_nrst) && $stable(od_sh)
		|-> o_out_div == od_exp) else $error("output divider wrong");
	a_forced_drive: assert property (frc_sel && $stable(frc_sel)
		&& $stable(frc_val) |-> o_osc_ctrl == frc_val)
		else $error("forced value not driven");
	a_forced_no_lock: assert property (frc_sel [*4] |-> !o_lock)
		else $error("lock while forced");
	a_lock_needs_en: assert property ((!en_loop) [*4] |-> !o_lock)
		else $error("lock while disabled");
	a_irq_pulse: assert property (o_lock_irq |=> !o_lock_irq)
		else $error("lock event too long");
	a_irq_on_rise: assert property ($rose(o_lock) |-> ##[0:1] o_lock_irq)
		else $error("lock event missing");
	a_frac_readback: assert property ($past(i_rd) && $past(i_addr) == 8'h76
		|-> o_rdata == frac_sh) else $error("fraction readback wrong");
	a_status_lock: assert property ($past(i_rd) && $past(i_addr) == 8'h81
		|-> o_rdata == {15'h0000, $past(o_lock)}) else $error("status wrong");
	c_lock: cover property ($rose(o_lock));
	c_forced: cover property (frc_sel && $stable(frc_sel));
	c_status: cover property ($past(i_rd) && $past(i_addr) == 8'h81 && o_lock);
endmodule
bind fcc_top fcc_top_chk fcc_top_chk_inst (.i_ref_clk, .i_nrst, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .i_vco_clk, .o_osc_ctrl, .o_osc_enable,
	.o_out_div, .o_loop_clk, .o_lock, .o_lock_irq);

// ==== fcc_top_test.sv ====
// Self-checking testbench for the loop control block
`timescale 1ns/1ns
module fcc_top_test;
	logic i_ref_clk, i_nrst, i_wr, i_rd, i_mclk, i_bclk, i_fclk, i_vco_clk;
	logic o_osc_enable, o_loop_clk, o_lock, o_lock_irq, rd_seen, o_system_clock_sel;
	logic [7:0] i_addr;
	logic [15:0] i_wdata, o_rdata;
	logic [15:0] irq_cnt = 16'h0000;
	logic [11:0] o_osc_level, lvl;
	logic [5:0] o_osc_ctrl, o_out_div;
	logic [2:0] run, o_ctrl_rate;
	logic [31:0] seed = 32'h626A;
	logic [15:0] exp_q[$];
	int miscompares = 0, n_compared = 0, cycles = 0, k;
	logic [7:0] ad [9] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'hF7, 8'hF8,
		8'h10, 8'h81};
	logic [15:0] rv [9] = '{16'h0000, 16'h0007, 16'h0000, 16'h2EE0,
		16'h0000, 16'h0000, 16'h0019, 16'h0000, 16'h0000};
	logic [15:0] wm [9] = '{16'h0007, 16'h3F77, 16'hFFFF, 16'h7FEF,
		16'h001B, 16'h0001, 16'h003F, 16'h0000, 16'h0000};
	logic [5:0] od [4] = '{6'h07, 6'h00, 6'h3F, 6'h02};
	logic [5:0] oe [4] = '{6'h07, 6'h03, 6'h3F, 6'h03};
	fcc_top fcc_top_inst (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_mclk, .i_bclk, .i_fclk, .i_vco_clk, .o_osc_ctrl,
		.o_osc_level, .o_osc_enable, .o_out_div, .o_ctrl_rate,
		.o_loop_clk, .o_system_clock_sel, .o_lock, .o_lock_irq);
	fcc_ref_src fcc_ref_src_inst (.i_run(run), .o_mclk(i_mclk),
		.o_bclk(i_bclk), .o_fclk(i_fclk), .o_vco_clk(i_vco_clk));
	// ----
	// Helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic test_done();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Clock
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	// Read watcher, lock event counter and hang limit
	always @(posedge i_ref_clk) begin
		rd_seen <= i_rd;
		cycles++;
		if (o_lock_irq === 1'b1)
			irq_cnt <= irq_cnt + 16'h0001;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	always @(negedge i_ref_clk)
		if (rd_seen === 1'b1)
			check(o_rdata, exp_q.pop_front());
	// ----
	// Main sequence
	// ----
	initial begin
		{i_nrst, i_wr, i_rd, i_addr, i_wdata, run} = '0;
		repeat (6) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		for (k = 0; k < 9; k++)
			rd(ad[k], rv[k]);
		for (k = 0; k < 9; k++)
			wr(ad[k], 16'hFFFF);
		for (k = 0; k < 9; k++)
			rd(ad[k], wm[k]);
		for (k = 0; k < 9; k++)
			wr(ad[k], 16'h0000);
		for (k = 0; k < 9; k++)
			rd(ad[k], 16'h0000);
		$display("test registers done");
		wr(8'hF7, 16'h0001);
		for (k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			wr(8'hF8, seed[15:0]);
			wr(8'h76, seed[31:16]);
			repeat (2) @(posedge i_ref_clk);
			check({10'h000, o_osc_ctrl}, {10'h000, seed[5:0]});
			rd(8'h76, seed[31:16]);
		end
		wr(8'hF8, 16'h0019);
		repeat (2) @(posedge i_ref_clk);
		check({10'h000, o_osc_ctrl}, 16'h0019);
		for (k = 0; k < 4; k++) begin
			wr(8'h75, {2'b00, od[k], 1'b0, k[2:0], 4'h0});
			@(negedge i_ref_clk);
			check({7'h00, o_ctrl_rate, o_out_div}, {7'h00, k[2:0], oe[k]});
			@(posedge i_ref_clk);
		end
		$display("test forced and divider done");
		wr(8'hF7, 16'h0000);
		wr(8'h77, 16'h0080);
		wr(8'h76, 16'h2000);
		wr(8'h75, 16'h0701);
		wr(8'h78, 16'h0009);
		wr(8'h80, 16'h0001);
		wr(8'h74, 16'h0002);
		check({15'h0000, o_osc_enable}, 16'h0001);
		wr(8'h74, 16'h0007);
		run <= 3'b001;
		repeat (800) @(posedge i_ref_clk);
		rd(8'h81, 16'h0000);
		check({15'h0000, o_system_clock_sel}, 16'h0001);
		run <= 3'b010;
		for (k = 0; k < 3000 && o_lock !== 1'b1; k++)
			@(posedge i_ref_clk);
		repeat (3) @(posedge i_ref_clk);
		check({15'h0000, o_lock}, 16'h0001);
		check(irq_cnt, 16'h0001);
		rd(8'h81, 16'h0001);
		run <= 3'b000;
		repeat (300) @(posedge i_ref_clk);
		lvl = o_osc_level;
		repeat (300) @(posedge i_ref_clk);
		check({15'h0000, o_lock}, 16'h0001);
		check({4'h0, o_osc_level}, {4'h0, lvl});
		wr(8'hF7, 16'h0001);
		repeat (3) @(posedge i_ref_clk);
		check({15'h0000, o_lock}, 16'h0000);
		$display("test lock done");
		test_done();
	end
endmodule
